// >>> logic/wsnc_pkg.sv
`default_nettype none

package wsnc_pkg;

    // Sizes of the array
    localparam int unsigned CHAN_N    = 4;
    localparam int unsigned SLOT_N    = 4;
    localparam int unsigned TAP_W     = 8;
    localparam int unsigned SLOT_W    = 9;
    localparam int unsigned WORD_W    = 24;
    localparam int unsigned BITCNT_W  = 5;

    // Field positions inside a stored slot
    localparam int unsigned BUF_MODE_POS = 8;

    // Word length check and counter reset
    localparam logic [BITCNT_W-1:0] WORD_BITS = 5'h18;
    localparam logic [BITCNT_W-1:0] BITCNT_RST = 5'h00;

    // Values after reset and wiper position limits
    localparam logic [SLOT_W-1:0] SLOT_RST    = 9'h080;
    localparam logic [TAP_W-1:0]  TAP_RST     = 8'h00;
    localparam logic [TAP_W-1:0]  TAP_MAX     = 8'hFF;
    localparam logic [TAP_W-1:0]  TAP_MIN     = 8'h00;
    localparam logic [WORD_W-1:0] SHIFT_RST   = 24'h000000;

    // Internal slot access time and its cycle count at 50 MHz
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned NVM_ACC_NS    = 1000;
    localparam int unsigned NVM_ACC_CYC   =
        (NVM_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ACC_CNT_W     = $clog2(NVM_ACC_CYC + 1);

    // Command opcodes
    typedef enum logic [3:0] {
        WSNC_OP_NOP     = 4'h0,
        WSNC_OP_RD_TAP  = 4'hC,
        WSNC_OP_WR_TAP  = 4'h4,
        WSNC_OP_RD_SLOT = 4'hA,
        WSNC_OP_PRG     = 4'h2,
        WSNC_OP_LOAD    = 4'hB,
        WSNC_OP_STORE   = 4'h3,
        WSNC_OP_UP      = 4'h7,
        WSNC_OP_DOWN    = 4'hF,
        WSNC_OP_SLEEP   = 4'h8,
        WSNC_OP_WAKE    = 4'h1,
        WSNC_OP_SWRST   = 4'h9
    } wsnc_op_t;

    // One serial command word, most significant bit first
    typedef struct packed {
        logic [3:0] opcode;
        logic       slot_select_hi;
        logic       slot_select_lo;
        logic       channel_select_hi;
        logic       channel_select_lo;
        logic [6:0] dont_care;
        logic [8:0] data;
    } wsnc_cmd_t;

    // Control states, one-hot
    typedef enum logic [2:0] {
        WSNC_ST_RECALL = 3'b001,
        WSNC_ST_IDLE   = 3'b010,
        WSNC_ST_BUSY   = 3'b100
    } wsnc_state_t;

endpackage : wsnc_pkg

`default_nettype wire

// >>> logic/wsnc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

// Function
// - Each channel keeps four nine-bit slots: eight-bit position plus buffer mode.
// - Reset and software reset copy slot 0 into each channel's wiper register.
// - Buffer mode 0 is off, 1 is on, independent per channel.
// - Direct writes leave buffer mode; only program then load or a reset recall changes it.
// - Direct write puts the host's full position into the chosen wiper register.
// - Up and down move the chosen wiper by exactly one step.
// - Up at top and down at bottom leave the position unchanged.
// - Restore loads one chosen slot into the chosen wiper register.
// - Program command writes the addressed slot with the nine data bits.
// - Store command copies current position and buffer mode into the slot.
// - Two slot-select bits of the instruction byte pick the slot.
// - Write lock low blocks slot changes; read and load still work.
// - Each slot access runs a cycle that ends before a new command.
// - Read, program, load and store commands give completion handshake.
// - Chip select falling releases ready high; high while commands accepted.
// - Handshake is valid for read, program, load and store only; other commands leave ready released.
// - A command is one 24-bit word, most significant bit first.
// - Channel and slot select bits decode binary to 0 to 3.
// - Inputs sampled on rising serial clock, outputs change on falling.
module wsnc_ctrl
    import wsnc_pkg::*;
#(
    parameter int unsigned ACC_CYC = NVM_ACC_CYC
)(
    // System clock and reset
    input  wire logic                         clk_sys_i,
    input  wire logic                         nrst_i,
    // Serial link pins
    input  wire logic                         sclk_i,
    input  wire logic                         cs_n_i,
    input  wire logic                         sdi_i,
    output logic                              sdo_o,
    output logic                              sdo_oe_n_o,
    // Open-drain completion pin
    output logic                              rdy_o,
    output logic                              rdy_oe_n_o,
    // Write lock, active low
    input  wire logic                         wp_n_i,
    // Wiper settings toward the resistor network
    output logic [CHAN_N-1:0][TAP_W-1:0]      wiper_pos_o,
    output logic [CHAN_N-1:0]                 buf_on_o,
    output logic                              sleep_o
);

    // Synchronisers: stage 0 feeds stage 1 only, stage 2 is for edges
    logic [2:0] sclk_s_q;
    logic [2:0] cs_s_q;
    logic [1:0] sdi_s_q;
    logic [1:0] wp_s_q;

    logic                                sclk_rise;
    logic                                sclk_fall;
    logic                                cs_fall;
    logic                                cs_rise;
    logic                                cs_low;

    logic [WORD_W-1:0]                   shift_q;
    logic [BITCNT_W-1:0]                 bitcnt_q;
    logic [WORD_W-1:0]                   out_q;
    logic [WORD_W-1:0]                   resp_q;
    logic                                word_ok;
    wsnc_cmd_t                           cmd;

    wsnc_state_t                         state_q;
    logic [ACC_CNT_W-1:0]                acc_q;
    logic                                sleep_q;
    logic                                recall_req_q;

    logic [SLOT_W-1:0]                   slot_q [CHAN_N][SLOT_N];
    logic [CHAN_N-1:0][TAP_W-1:0]        tap_q;
    logic [CHAN_N-1:0]                   mode_q;

    logic [1:0]                          chan;
    logic [1:0]                          slot;
    logic                                exec;
    logic                                locked;
    logic                                is_slot_op;

    // Decode the handshaked commands that run an access cycle
    function automatic logic needs_access(input logic [3:0] op);
        case (op)
            WSNC_OP_RD_TAP, WSNC_OP_RD_SLOT, WSNC_OP_PRG,
            WSNC_OP_LOAD, WSNC_OP_STORE:
                needs_access = 1'b1;
            default:
                needs_access = 1'b0;
        endcase
    endfunction : needs_access

    // Pin synchronisers
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            sclk_s_q <= 3'h0;
            cs_s_q   <= 3'h7;
            sdi_s_q  <= 2'h0;
            wp_s_q   <= 2'h3;
        end
        else
        begin
            sclk_s_q <= {sclk_s_q[1:0], sclk_i};
            cs_s_q   <= {cs_s_q[1:0], cs_n_i};
            sdi_s_q  <= {sdi_s_q[0], sdi_i};
            wp_s_q   <= {wp_s_q[0], wp_n_i};
        end
    end

    // Edges found on the second stage against the third
    assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
    assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
    assign cs_fall   = ~cs_s_q[1] & cs_s_q[2];
    assign cs_rise   = cs_s_q[1] & ~cs_s_q[2];
    assign cs_low    = ~cs_s_q[1];
    assign locked    = ~wp_s_q[1];

    // Input shifter, rising clock only while selected
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            shift_q  <= SHIFT_RST;
            bitcnt_q <= BITCNT_RST;
        end
        else if (cs_fall)
        begin
            bitcnt_q <= BITCNT_RST;
        end
        else if (cs_low && sclk_rise)
        begin
            shift_q <= {shift_q[WORD_W-2:0], sdi_s_q[1]};
            // Count one past a full word so over-long frames are dropped as well
            if (bitcnt_q <= WORD_BITS)
            begin
                bitcnt_q <= bitcnt_q + 5'h01;
            end
        end
    end

    // Only a word of exactly 24 bits is executed; short or long frames drop
    assign word_ok = (bitcnt_q == WORD_BITS);
    assign cmd     = wsnc_cmd_t'(shift_q);
    assign chan    = {cmd.channel_select_hi, cmd.channel_select_lo};
    assign slot    = {cmd.slot_select_hi, cmd.slot_select_lo};
    // Commands arriving during an access cycle are not accepted
    assign exec    = cs_rise && word_ok && (state_q == WSNC_ST_IDLE);
    assign is_slot_op = needs_access(cmd.opcode);

    // Control sequence: recall after reset, access cycle, idle
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            state_q <= WSNC_ST_RECALL;
            acc_q   <= '0;
        end
        else
        begin
            case (state_q)
                WSNC_ST_RECALL:
                begin
                    state_q <= WSNC_ST_IDLE;
                end
                WSNC_ST_IDLE:
                begin
                    if (recall_req_q)
                    begin
                        state_q <= WSNC_ST_RECALL;
                    end
                    else if (exec && is_slot_op && !sleep_q)
                    begin
                        state_q <= WSNC_ST_BUSY;
                        acc_q   <= ACC_CNT_W'(ACC_CYC - 1);
                    end
                end
                WSNC_ST_BUSY:
                begin
                    if (acc_q == '0)
                    begin
                        state_q <= WSNC_ST_IDLE;
                    end
                    else
                    begin
                        acc_q <= acc_q - 1'b1;
                    end
                end
                default:
                begin
                    state_q <= WSNC_ST_IDLE;
                end
            endcase
        end
    end

    // Sleep flag and software reset request
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            sleep_q      <= 1'b0;
            recall_req_q <= 1'b0;
        end
        else
        begin
            recall_req_q <= 1'b0;
            if (exec)
            begin
                if (cmd.opcode == WSNC_OP_WAKE)
                begin
                    sleep_q <= 1'b0;
                end
                else if (!sleep_q && cmd.opcode == WSNC_OP_SLEEP)
                begin
                    sleep_q <= 1'b1;
                end
                else if (!sleep_q && cmd.opcode == WSNC_OP_SWRST)
                begin
                    recall_req_q <= 1'b1;
                end
            end
        end
    end

    // Slot store; nrst stands for power-up so the slots reset to a default
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            for (int c = 0; c < CHAN_N; c++)
            begin
                for (int s = 0; s < SLOT_N; s++)
                begin
                    slot_q[c][s] <= SLOT_RST;
                end
            end
        end
        // A locked write still goes busy but leaves the slot alone
        else if (exec && !sleep_q && !locked)
        begin
            if (cmd.opcode == WSNC_OP_PRG)
            begin
                slot_q[chan][slot] <= cmd.data;
            end
            else if (cmd.opcode == WSNC_OP_STORE)
            begin
                slot_q[chan][slot] <= {mode_q[chan], tap_q[chan]};
            end
        end
    end

    // Wiper positions and buffer modes, one per channel
    generate
        for (genvar g = 0; g < CHAN_N; g++)
        begin : g_chan
            always_ff @(posedge clk_sys_i)
            begin
                if (!nrst_i)
                begin
                    tap_q[g]  <= TAP_RST;
                    mode_q[g] <= 1'b0;
                end
                else if (state_q == WSNC_ST_RECALL)
                begin
                    tap_q[g]  <= slot_q[g][0][TAP_W-1:0];
                    mode_q[g] <= slot_q[g][0][BUF_MODE_POS];
                end
                else if (exec && !sleep_q && chan == 2'(g))
                begin
                    case (cmd.opcode)
                        WSNC_OP_WR_TAP:
                        begin
                            tap_q[g] <= cmd.data[TAP_W-1:0];
                        end
                        WSNC_OP_UP:
                        begin
                            if (tap_q[g] != TAP_MAX)
                            begin
                                tap_q[g] <= tap_q[g] + 8'h01;
                            end
                        end
                        WSNC_OP_DOWN:
                        begin
                            if (tap_q[g] != TAP_MIN)
                            begin
                                tap_q[g] <= tap_q[g] - 8'h01;
                            end
                        end
                        WSNC_OP_LOAD:
                        begin
                            tap_q[g]  <= slot_q[g][slot][TAP_W-1:0];
                            mode_q[g] <= slot_q[g][slot][BUF_MODE_POS];
                        end
                        default:
                        begin
                            tap_q[g] <= tap_q[g];
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Read answers; shifted out during the next frame
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            resp_q <= SHIFT_RST;
        end
        else if (exec && !sleep_q)
        begin
            if (cmd.opcode == WSNC_OP_RD_TAP)
            begin
                resp_q <= {shift_q[WORD_W-1:SLOT_W], mode_q[chan], tap_q[chan]};
            end
            else if (cmd.opcode == WSNC_OP_RD_SLOT)
            begin
                resp_q <= {shift_q[WORD_W-1:SLOT_W], slot_q[chan][slot]};
            end
        end
    end

    // Output shifter: first bit on select, the rest on falling clock
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            out_q <= SHIFT_RST;
        end
        else if (cs_fall)
        begin
            out_q <= resp_q;
        end
        else if (cs_low && sclk_fall)
        begin
            out_q <= {out_q[WORD_W-2:0], 1'b0};
        end
    end

    // Open-drain pins: only ever pull low, released otherwise
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            sdo_oe_n_o <= 1'b1;
            rdy_oe_n_o <= 1'b1;
        end
        else
        begin
            // On select the fresh answer drives at once, not the stale shifter bit
            sdo_oe_n_o <= ~(cs_low & ~(cs_fall ? resp_q[WORD_W-1] : out_q[WORD_W-1]));
            // Busy pulls low; a new select never falls during busy by host contract
            rdy_oe_n_o <= (state_q != WSNC_ST_BUSY) || cs_fall;
        end
    end

    assign sdo_o = 1'b0;
    assign rdy_o = 1'b0;

    // Settings toward the analog side
    assign wiper_pos_o = tap_q;
    assign buf_on_o    = mode_q;
    assign sleep_o     = sleep_q;

endmodule : wsnc_ctrl

`default_nettype wire

// >>> sim/wsnc_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none

module wsnc_chk
    import wsnc_pkg::*;
#(
    parameter int unsigned ACC_CYC = NVM_ACC_CYC
)(
    // Clock and reset
    input  wire logic                         clk_sys_i,
    input  wire logic                         nrst_i,
    // Link and lock pins
    input  wire logic                         sclk_i,
    input  wire logic                         cs_n_i,
    input  wire logic                         sdi_i,
    input  wire logic                         sdo_o,
    input  wire logic                         sdo_oe_n_o,
    input  wire logic                         rdy_o,
    input  wire logic                         rdy_oe_n_o,
    input  wire logic                         wp_n_i,
    // Wiper side
    input  wire logic [CHAN_N-1:0][TAP_W-1:0] wiper_pos_o,
    input  wire logic [CHAN_N-1:0]            buf_on_o,
    input  wire logic                         sleep_o
);
    // Length of the current busy run; wide so a stuck pin cannot wrap it
    logic [15:0] busy_len_q;
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i || rdy_oe_n_o)
            busy_len_q <= 16'h0000;
        else
            busy_len_q <= busy_len_q + 16'h0001;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    // Recall of the reset slot value, mode off
    AST_RECALL: assert property ($rose(nrst_i) |-> ##[1:3] (wiper_pos_o == {4{8'h80}} && buf_on_o == 4'h0))
        else $error("wipers not recalled after reset");
    AST_BUSY_LEN: assert property ($rose(rdy_oe_n_o) |-> busy_len_q == 16'(ACC_CYC))
        else $error("busy run has wrong length");
    AST_BUSY_MAX: assert property (busy_len_q <= 16'(ACC_CYC))
        else $error("busy run too long");
    AST_BUSY_START: assert property ($fell(rdy_oe_n_o) |-> cs_n_i && $past(cs_n_i, 2))
        else $error("busy began inside a frame");
    AST_FRAME_READY: assert property (!cs_n_i [*6] |-> rdy_oe_n_o)
        else $error("ready not released during frame");
    AST_WIPER_AT_END: assert property (!$stable(wiper_pos_o) |-> cs_n_i && $past(cs_n_i, 2))
        else $error("wiper moved inside a frame");
    // Slot access in progress must not disturb the settings
    AST_BUSY_FROZEN: assert property (!rdy_oe_n_o && !$past(rdy_oe_n_o) |-> $stable(wiper_pos_o) && $stable(buf_on_o))
        else $error("settings moved during access cycle");
    AST_SDO_IDLE: assert property (cs_n_i && $past(cs_n_i, 5) |-> sdo_oe_n_o)
        else $error("data out driven while deselected");
    AST_SDO_ON_FALL: assert property ($changed(sdo_oe_n_o) |-> !$past(sclk_i, 2))
        else $error("data out changed away from falling clock");
    AST_OD_VALUES: assert property (!sdo_o && !rdy_o)
        else $error("open-drain value not low");
endmodule : wsnc_chk

bind wsnc_ctrl wsnc_chk #(.ACC_CYC(ACC_CYC)) chk_u (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .sdi_i(sdi_i),
    .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .rdy_o(rdy_o), .rdy_oe_n_o(rdy_oe_n_o), .wp_n_i(wp_n_i),
    .wiper_pos_o(wiper_pos_o), .buf_on_o(buf_on_o), .sleep_o(sleep_o));

`default_nettype wire

// >>> sim/wsnc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module wsnc_host_model (
    // System clock paces the host
    input  wire logic clk_sys_i,
    // Open-drain lines as seen through pull-ups
    input  wire logic sdo_i,
    input  wire logic rdy_i,
    // Serial pins driven by the host
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o
);
    // Clock rests low between frames
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b1;
    end

    // One frame of n bits, then a bounded poll of the ready line
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rx,
                        output logic busy, output logic rdy);
        rx   = 24'h000000;
        busy = 1'b0;
        @(posedge clk_sys_i);
        cs_n_o <= 1'b0;
        for (int i = 23; i > 23 - n; i--)
        begin
            sdi_o <= w[i];
            repeat (4) @(posedge clk_sys_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            // Sample late in the high phase: the bit moved on the last fall and has settled
            rx[i] = sdo_i;
            sclk_o <= 1'b0;
        end
        repeat (4) @(posedge clk_sys_i);
        cs_n_o <= 1'b1;
        sdi_o  <= ~sdi_o; // Released line must not look like held data
        for (int k = 0; k < 40; k++)
        begin
            @(posedge clk_sys_i);
            if (rdy_i === 1'b0) busy = 1'b1;
        end
        rdy = rdy_i;
    endtask : xfer
endmodule : wsnc_host_model

`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH t=%0t got %0h expected %0h", $time, got, exp); end end

module tb;
    import wsnc_pkg::*;

    // Command fields beside the wiper state they should leave
    typedef struct packed {
        wsnc_op_t   op;
        logic [1:0] slot;
        logic [1:0] ch;
        logic [8:0] data;
        logic [7:0] tap;
        logic       bufm;
        logic       busy;
    } wsnc_row_t;

    // Short access cycle keeps the run brief
    localparam int unsigned ACC = 4;
    localparam wsnc_row_t ROWS [15] = '{
        '{WSNC_OP_WR_TAP, 2'h0, 2'h1, 9'h1FF, 8'hFF, 1'b0, 1'b0},
        '{WSNC_OP_UP,     2'h0, 2'h1, 9'h000, 8'hFF, 1'b0, 1'b0},
        '{WSNC_OP_DOWN,   2'h0, 2'h1, 9'h000, 8'hFE, 1'b0, 1'b0},
        '{WSNC_OP_WR_TAP, 2'h0, 2'h2, 9'h000, 8'h00, 1'b0, 1'b0},
        '{WSNC_OP_DOWN,   2'h0, 2'h2, 9'h000, 8'h00, 1'b0, 1'b0},
        '{WSNC_OP_UP,     2'h0, 2'h2, 9'h000, 8'h01, 1'b0, 1'b0},
        '{WSNC_OP_PRG,    2'h2, 2'h3, 9'h1A5, 8'h80, 1'b0, 1'b1},
        '{WSNC_OP_LOAD,   2'h2, 2'h3, 9'h000, 8'hA5, 1'b1, 1'b1},
        '{WSNC_OP_STORE,  2'h3, 2'h1, 9'h000, 8'hFE, 1'b0, 1'b1},
        '{WSNC_OP_WR_TAP, 2'h0, 2'h1, 9'h033, 8'h33, 1'b0, 1'b0},
        '{WSNC_OP_LOAD,   2'h3, 2'h1, 9'h000, 8'hFE, 1'b0, 1'b1},
        '{WSNC_OP_WR_TAP, 2'h0, 2'h3, 9'h012, 8'h12, 1'b1, 1'b0},
        '{WSNC_OP_STORE,  2'h1, 2'h3, 9'h000, 8'h12, 1'b1, 1'b1},
        '{WSNC_OP_LOAD,   2'h2, 2'h3, 9'h000, 8'hA5, 1'b1, 1'b1},
        '{WSNC_OP_LOAD,   2'h1, 2'h3, 9'h000, 8'h12, 1'b1, 1'b1}
    };

    logic                         clk_sys_i;
    logic                         nrst_i;
    logic                         wp_n;
    logic                         sclk;
    logic                         cs_n;
    logic                         sdi;
    logic                         sdo;
    logic                         sdo_oe_n;
    logic                         rdy;
    logic                         rdy_oe_n;
    logic                         sleep;
    logic [CHAN_N-1:0][TAP_W-1:0] wiper;
    logic [CHAN_N-1:0]            buf_on;
    logic [WORD_W-1:0]            rx;
    logic                         busy;
    int                           error_cnt;
    int                           n_tests;
    // Both open-drain lines carry pull-ups
    wire logic                    sdo_line = sdo_oe_n ? 1'b1 : sdo;
    wire logic                    rdy_line = rdy_oe_n ? 1'b1 : rdy;

    wsnc_ctrl #(.ACC_CYC(ACC)) dut_u (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
        .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .rdy_o(rdy), .rdy_oe_n_o(rdy_oe_n), .wp_n_i(wp_n),
        .wiper_pos_o(wiper), .buf_on_o(buf_on), .sleep_o(sleep));
    wsnc_host_model host_u (
        .clk_sys_i(clk_sys_i), .sdo_i(sdo_line), .rdy_i(rdy_line),
        .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));

    function automatic logic [WORD_W-1:0] mk(wsnc_op_t op, logic [1:0] sl, logic [1:0] ch, logic [8:0] d);
        return {op, sl, ch, 7'h55, d};
    endfunction : mk

    // Counts and verdict, the single exit of the run
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // One frame; a ready line that never returns ends the run
    task automatic run(input logic [WORD_W-1:0] w, input int n);
        logic ok;
        host_u.xfer(w, n, rx, busy, ok);
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t ready line stuck low", $time);
            test_done();
        end
    endtask : run

    // 50 MHz system clock
    initial
    begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    initial
    begin
        error_cnt = 0;
        n_tests   = 0;
        nrst_i    = 1'b0;
        wp_n      = 1'b1;
        repeat (8) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        `CHK(wiper, {4{8'h80}})
        `CHK(buf_on, 4'h0)
        $display("Test reset done");
        foreach (ROWS[r])
        begin
            run(mk(ROWS[r].op, ROWS[r].slot, ROWS[r].ch, ROWS[r].data), 24);
            `CHK(wiper[ROWS[r].ch], ROWS[r].tap)
            `CHK(buf_on[ROWS[r].ch], ROWS[r].bufm)
            `CHK(busy, ROWS[r].busy)
        end
        `CHK(wiper[0], 8'h80)
        $display("Test table done");
        // Read answer comes out in the following frame
        run(mk(WSNC_OP_RD_TAP, 2'h0, 2'h3, 9'h000), 24);
        `CHK(busy, 1'b1)
        run(mk(WSNC_OP_NOP, 2'h0, 2'h0, 9'h000), 24);
        `CHK(rx, {8'hC3, 7'h55, 9'h112})
        $display("Test read done");
        // Locked: program and store change nothing but still hand shake
        wp_n <= 1'b0;
        run(mk(WSNC_OP_PRG, 2'h2, 2'h3, 9'h000), 24);
        `CHK(busy, 1'b1)
        run(mk(WSNC_OP_STORE, 2'h2, 2'h3, 9'h000), 24);
        `CHK(busy, 1'b1)
        run(mk(WSNC_OP_RD_SLOT, 2'h2, 2'h3, 9'h000), 24);
        run(mk(WSNC_OP_NOP, 2'h0, 2'h0, 9'h000), 24);
        `CHK(rx[8:0], 9'h1A5)
        run(mk(WSNC_OP_WR_TAP, 2'h0, 2'h3, 9'h000), 24);
        run(mk(WSNC_OP_LOAD, 2'h2, 2'h3, 9'h000), 24);
        `CHK(wiper[3], 8'hA5)
        wp_n <= 1'b1;
        $display("Test lock done");
        // A frame one bit short is dropped
        run(mk(WSNC_OP_WR_TAP, 2'h0, 2'h0, 9'h0AA), 23);
        `CHK(wiper[0], 8'h80)
        $display("Test short frame done");
        // Asleep only wake is taken; other commands leave the wipers alone
        run(mk(WSNC_OP_SLEEP, 2'h0, 2'h0, 9'h000), 24);
        `CHK(sleep, 1'b1)
        run(mk(WSNC_OP_WR_TAP, 2'h0, 2'h0, 9'h011), 24);
        `CHK(wiper[0], 8'h80)
        run(mk(WSNC_OP_WAKE, 2'h0, 2'h0, 9'h000), 24);
        `CHK(sleep, 1'b0)
        $display("Test sleep done");
        run(mk(WSNC_OP_PRG, 2'h0, 2'h2, 9'h1C3), 24);
        run(mk(WSNC_OP_SWRST, 2'h0, 2'h0, 9'h000), 24);
        `CHK(wiper, {8'h80, 8'hC3, 8'h80, 8'h80})
        `CHK(buf_on, 4'h4)
        $display("Test software reset done");
        nrst_i <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        `CHK(wiper, {4{8'h80}})
        `CHK(buf_on, 4'h0)
        $display("Test second reset done");
        test_done();
    end
endmodule : tb

`default_nettype wire
